// *** hw/hseq_top.sv ***
// Homing sequencer: APB registers, sensor handling and the homing state machine.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
// How it works
// - Method 17 starts negative, leaves the limit, backs the two-sensor count, home_position_sensor.
// - Method 18 is the same limit sequence but starts in the positive direction.
// - Vendor two-sensor, negative, no extra signals behaves as method 17.
// - Vendor two-sensor, positive, no extra signals behaves as method 18.
// - Methods 35 and 37 preset home unless the drive is operation enabled.
// - Three-sensor seeks at search speed, leaves limits, stops on home ON edge.
// - Three-sensor with extra signal finishes when it arrives while home is ON.
// - Two-sensor seeks at start speed, leaves limit, moves back count, home_position_sensor.
// - Two-sensor, one-way, push with extra signal finish when that signal arrives.
// - One-way stops on home, leaves at zero speed, moves one-way amount, home_position_sensor.
// - Leaving home sensor while decelerating in one-way raises alarm 62h.
// - Push seeks the stopper, reverses and stops after the first-entry count.
// - Push approaches again, reverses, stops after the push count, home_position_sensor.
// - Method value minus one selects the vendor homing modes.
// - Mode field: 0 two-sensor, 1 three-sensor, 2 one-way, 3 push.
// - Signal select: 0 off, 1 timing output, 2 zero-position output.
module hseq_top
  import hseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire hseq_pins_t pins_i,
  input wire logic op_enabled_i,
  output logic step_o,
  output logic dir_o,
  output logic busy_o,
  output logic done_o,
  output logic error_o,
  output logic [7:0] alarm_o,
  output logic [31:0] position_o,
  output logic irq_o
);
  typedef struct packed {
    hseq_state_t st;
    logic [7:0] method;
    logic [31:0] cfg;
    logic [31:0] spd_sw;
    logic [31:0] spd_zero;
    logic [31:0] spd_start;
    logic [31:0] back2;
    logic [31:0] oneway;
    logic [31:0] push1;
    logic [31:0] push2;
    logic [31:0] decel;
    logic [1:0] mode;
    logic dir;
    logic input_a_en;
    logic [1:0] tz;
    logic second;
    logic [1:0] spd;
    logic [31:0] cnt;
    logic [31:0] pos;
    logic busy;
    logic done;
    logic err;
    logic [7:0] alarm;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic irq;
    logic step;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    hseq_pins_t prev;
  } hseq_top_st_t;
  hseq_top_st_t s;
  hseq_top_st_t next_s;
  hseq_pins_t pin;
  logic tick;
  logic [31:0] speed;
  logic acc_en;
  logic wr_en;
  logic start;
  logic home_rise;
  logic lim;
  logic lim_back;
  logic ext_on;
  logic ext_hit;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic finish;
  logic [1:0] cfg_mode;
  logic [1:0] cfg_tz;

  // Sensors are asynchronous to the sequencer, so all of them are resynchronised.
  hseq_sync #(.W($bits(hseq_pins_t))) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(pins_i),
    .q_o(pin)
  );

  always_comb begin
    unique case (s.spd)
      SPD_SW: speed = s.spd_sw;
      SPD_START: speed = s.spd_start;
      SPD_ZERO: speed = s.spd_zero;
      SPD_STOP: speed = '0;
    endcase
  end

  hseq_step_gen u_step (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(s.st != ST_IDLE),
    .speed_i(speed),
    .tick_o(tick)
  );

  assign acc_en = psel_i && penable_i && !s.pready;
  assign wr_en = acc_en && pwrite_i;
  assign start = wr_en && paddr_i == OFS_CMD && pwdata_i[0] && s.st == ST_IDLE;
  assign home_rise = pin.home && !s.prev.home;
  assign lim = s.dir ? pin.fwd : pin.rev;
  assign lim_back = s.dir ? pin.rev : pin.fwd;
  assign ext_on = s.input_a_en || s.tz != TZ_OFF;
  assign ext_hit = (s.input_a_en && pin.input_a && !s.prev.input_a)
      || (s.tz == TZ_TIM && pin.tim && !s.prev.tim)
      || (s.tz == TZ_ZERO && pin.zero && !s.prev.zero);
  assign cfg_mode = s.cfg[CFG_MODE_LSB +: 2];
  assign cfg_tz = s.cfg[CFG_TZ_LSB +: 2];
  assign finish = (s.st == ST_EXT) && ext_hit && (s.mode != MODE_THREE || pin.home);

  always_comb begin
    next_s = s;
    next_s.step = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.prev = pin;
    irq_set = '0;
    irq_clr = '0;
    if (acc_en) begin
      next_s.pready = 1'b1;
      if (pwrite_i) begin
        unique case (paddr_i)
          OFS_METHOD: next_s.method = pwdata_i[7:0];
          OFS_CFG: next_s.cfg = pwdata_i;
          OFS_CMD: next_s.cnt = s.cnt;
          OFS_SPD_SW: next_s.spd_sw = pwdata_i;
          OFS_SPD_ZERO: next_s.spd_zero = pwdata_i;
          OFS_SPD_START: next_s.spd_start = pwdata_i;
          OFS_BACK2: next_s.back2 = pwdata_i;
          OFS_ONEWAY: next_s.oneway = pwdata_i;
          OFS_PUSH1: next_s.push1 = pwdata_i;
          OFS_PUSH2: next_s.push2 = pwdata_i;
          OFS_DECEL: next_s.decel = pwdata_i;
          OFS_STATUS, OFS_POS: next_s.cnt = s.cnt;
          OFS_IRQ_ST: irq_clr = pwdata_i[1:0];
          OFS_IRQ_MASK: next_s.irq_mask = pwdata_i[1:0];
          default: next_s.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr_i)
          OFS_METHOD: next_s.prdata = {24'h00_0000, s.method};
          OFS_CFG: next_s.prdata = s.cfg;
          OFS_CMD: next_s.prdata = '0;
          OFS_SPD_SW: next_s.prdata = s.spd_sw;
          OFS_SPD_ZERO: next_s.prdata = s.spd_zero;
          OFS_SPD_START: next_s.prdata = s.spd_start;
          OFS_BACK2: next_s.prdata = s.back2;
          OFS_ONEWAY: next_s.prdata = s.oneway;
          OFS_PUSH1: next_s.prdata = s.push1;
          OFS_PUSH2: next_s.prdata = s.push2;
          OFS_DECEL: next_s.prdata = s.decel;
          OFS_STATUS: next_s.prdata = {16'h0000, s.alarm, 5'h00, s.err, s.done, s.busy};
          OFS_IRQ_ST: next_s.prdata = {30'h0000_0000, s.irq_st};
          OFS_IRQ_MASK: next_s.prdata = {30'h0000_0000, s.irq_mask};
          OFS_POS: next_s.prdata = s.pos;
          default: begin
            next_s.prdata = '0;
            next_s.pslverr = 1'b1;
          end
        endcase
      end
    end
    // A tick still in flight when the sequence ends must not move the motor off home.
    if (tick && s.st != ST_IDLE) begin
      next_s.step = 1'b1;
      next_s.pos = s.dir ? s.pos + 32'h0000_0001 : s.pos - 32'h0000_0001;
      if ((s.st == ST_DECEL || s.st == ST_MOVE) && s.cnt != '0) begin
        next_s.cnt = s.cnt - 32'h0000_0001;
      end
    end
    unique case (s.st)
      ST_IDLE: begin
        if (start) begin
          next_s.done = 1'b0;
          next_s.err = 1'b0;
          next_s.alarm = ALARM_NONE;
          next_s.second = 1'b0;
          if (s.method == METH_VENDOR) begin
            next_s.mode = cfg_mode;
            next_s.dir = s.cfg[CFG_DIR_BIT];
            next_s.input_a_en = s.cfg[CFG_INPUT_A_BIT];
            next_s.tz = cfg_tz;
            next_s.st = ST_SEEK;
            next_s.busy = 1'b1;
            next_s.spd = (cfg_mode == MODE_TWO) ? SPD_START : SPD_SW;
          end else if (s.method == METH_LS_NEG || s.method == METH_LS_POS) begin
            next_s.mode = MODE_TWO;
            next_s.dir = (s.method == METH_LS_POS);
            next_s.input_a_en = 1'b0;
            next_s.tz = TZ_OFF;
            next_s.st = ST_SEEK;
            next_s.busy = 1'b1;
            next_s.spd = SPD_START;
          end else if ((s.method == METH_PRE_A || s.method == METH_PRE_B) && !op_enabled_i) begin
            next_s.pos = '0;
            next_s.done = 1'b1;
            irq_set[IRQ_DONE] = 1'b1;
          end else begin
            next_s.err = 1'b1;
            irq_set[IRQ_ERR] = 1'b1;
          end
        end
      end
      ST_SEEK: begin
        if (s.mode == MODE_THREE && home_rise) begin
          next_s.st = ext_on ? ST_EXT : ST_IDLE;
          next_s.spd = ext_on ? SPD_ZERO : SPD_STOP;
        end else if ((s.mode == MODE_THREE || s.mode == MODE_TWO) && lim) begin
          next_s.dir = !s.dir;
          next_s.st = ST_LEAVE;
        end else if (s.mode == MODE_ONEWAY && home_rise) begin
          next_s.st = ST_DECEL;
          next_s.cnt = s.decel;
        end else if (s.mode == MODE_PUSH && pin.pressed) begin
          next_s.dir = !s.dir;
          next_s.st = ST_MOVE;
          next_s.cnt = s.second ? s.push2 : s.push1;
        end
      end
      ST_LEAVE: begin
        if (!lim_back) begin
          next_s.st = (s.mode == MODE_TWO) ? ST_MOVE : ST_SEEK;
          next_s.cnt = s.back2;
        end
      end
      ST_DECEL: begin
        // A deceleration ramp too long for the sensor width ends in this alarm.
        if (!pin.home) begin
          next_s.st = ST_IDLE;
          next_s.spd = SPD_STOP;
          next_s.busy = 1'b0;
          next_s.err = 1'b1;
          next_s.alarm = ALARM_HOME_ERR;
          irq_set[IRQ_ERR] = 1'b1;
        end else if (s.cnt == '0) begin
          next_s.st = ST_OUT;
          next_s.spd = SPD_ZERO;
        end
      end
      ST_OUT: begin
        if (!pin.home) begin
          next_s.st = ST_MOVE;
          next_s.cnt = s.oneway;
        end
      end
      ST_MOVE: begin
        if (s.cnt == '0) begin
          if (s.mode == MODE_PUSH && !s.second) begin
            next_s.second = 1'b1;
            next_s.dir = !s.dir;
            next_s.st = ST_SEEK;
            next_s.spd = SPD_SW;
          end else begin
            next_s.st = ext_on ? ST_EXT : ST_IDLE;
            next_s.spd = ext_on ? SPD_ZERO : SPD_STOP;
          end
        end
      end
      ST_EXT: begin
        if (finish) begin
          next_s.st = ST_IDLE;
          next_s.spd = SPD_STOP;
        end
      end
    endcase
    if (s.st != ST_IDLE && next_s.st == ST_IDLE && !next_s.err) begin
      next_s.pos = '0;
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
      irq_set[IRQ_DONE] = 1'b1;
    end
    // Set wins over a clear in the same cycle, so no event is lost.
    next_s.irq_st = (s.irq_st & ~irq_clr) | irq_set;
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
      s.method <= RST_METHOD;
      s.cfg <= RST_CFG;
      s.spd_sw <= RST_SPD_SW;
      s.spd_zero <= RST_SPD_ZERO;
      s.spd_start <= RST_SPD_START;
      s.back2 <= RST_BACK2;
      s.oneway <= RST_ONEWAY;
      s.push1 <= RST_PUSH1;
      s.push2 <= RST_PUSH2;
      s.decel <= RST_DECEL;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign step_o = s.step;
  assign dir_o = s.dir;
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign error_o = s.err;
  assign alarm_o = s.alarm;
  assign position_o = s.pos;
  assign irq_o = s.irq;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_push_press;
    s.st == ST_SEEK && s.mode == MODE_PUSH && pin.pressed && !s.second;
  endsequence
  sequence s_push_back;
    s.st == ST_MOVE && s.cnt == s.push1 && s.dir != $past(s.dir);
  endsequence

  a_ls_neg_start: assert property (start && s.method == METH_LS_NEG |=>
      s.st == ST_SEEK && !s.dir && s.mode == MODE_TWO && s.spd == SPD_START)
    else $error("method 17 start wrong");
  a_ls_pos_start: assert property (start && s.method == METH_LS_POS |=>
      s.st == ST_SEEK && s.dir && s.mode == MODE_TWO && !ext_on)
    else $error("method 18 start wrong");
  a_vendor_two: assert property (start && s.method == METH_VENDOR
      && s.cfg[7:0] == 8'h00 |=> s.mode == MODE_TWO && !s.dir && !ext_on)
    else $error("vendor two-sensor negative wrong");
  a_vendor_two_pos: assert property (start && s.method == METH_VENDOR
      && s.cfg[7:0] == 8'h04 |=> s.mode == MODE_TWO && s.dir && s.spd == SPD_START)
    else $error("vendor two-sensor positive wrong");
  a_preset_home: assert property (start && s.method == METH_PRE_B && !op_enabled_i
      |=> s.pos == 32'h0000_0000 && s.done && s.st == ST_IDLE)
    else $error("preset did not home");
  a_three_stop: assert property (s.st == ST_SEEK && s.mode == MODE_THREE
      && home_rise && !ext_on |=> s.st == ST_IDLE && s.done && s.pos == 32'h0000_0000)
    else $error("three-sensor did not stop on home");
  a_ext_three_hold: assert property (s.st == ST_EXT && s.mode == MODE_THREE
      && !pin.home |=> s.st == ST_EXT && !s.done)
    else $error("finished without home sensor");
  a_two_back: assert property (s.st == ST_LEAVE && s.mode == MODE_TWO && !lim_back
      |=> s.st == ST_MOVE && s.cnt == s.back2)
    else $error("two-sensor back count not loaded");
  a_ext_done: assert property (s.st == ST_EXT && s.mode != MODE_THREE && ext_hit
      |=> s.done && !s.busy ##1 s.irq_st[IRQ_DONE])
    else $error("extra signal did not finish");
  a_oneway_alarm: assert property (s.st == ST_DECEL && !pin.home
      |=> s.err && s.alarm == 8'h62 && s.st == ST_IDLE)
    else $error("one-way alarm missing");
  a_push_first: assert property (s_push_press |=> s_push_back)
    else $error("push first retreat wrong");
  a_push_final: assert property (s.st == ST_MOVE && s.mode == MODE_PUSH && s.second
      && s.cnt == 32'h0000_0000 && !ext_on |=> s.done && s.pos == 32'h0000_0000)
    else $error("push final home wrong");
endmodule : hseq_top

// *** hw/hseq_pkg.sv ***
// Package with constants, register map and types of the homing sequencer.
package hseq_pkg;
  localparam logic [31:0] CLK_HZ = 32'h0EE6_B280;
  localparam int AW = 8;
  localparam logic [7:0] OFS_METHOD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_SPD_SW = 8'h0C;
  localparam logic [7:0] OFS_SPD_ZERO = 8'h10;
  localparam logic [7:0] OFS_SPD_START = 8'h14;
  localparam logic [7:0] OFS_BACK2 = 8'h18;
  localparam logic [7:0] OFS_ONEWAY = 8'h1C;
  localparam logic [7:0] OFS_PUSH1 = 8'h20;
  localparam logic [7:0] OFS_PUSH2 = 8'h24;
  localparam logic [7:0] OFS_DECEL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_IRQ_ST = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  localparam logic [7:0] OFS_POS = 8'h38;
  localparam logic [7:0] RST_METHOD = 8'hFF;
  localparam logic [31:0] RST_CFG = 32'h0000_0005;
  localparam logic [31:0] RST_SPD_SW = 32'h0000_2710;
  localparam logic [31:0] RST_SPD_ZERO = 32'h0000_1388;
  localparam logic [31:0] RST_SPD_START = 32'h0000_1388;
  localparam logic [31:0] RST_BACK2 = 32'h0000_1388;
  localparam logic [31:0] RST_ONEWAY = 32'h0000_1388;
  localparam logic [31:0] RST_PUSH1 = 32'h0000_0000;
  localparam logic [31:0] RST_PUSH2 = 32'h0000_1388;
  localparam logic [31:0] RST_DECEL = 32'h0000_0064;
  localparam logic [7:0] METH_VENDOR = 8'hFF;
  localparam logic [7:0] METH_LS_NEG = 8'h11;
  localparam logic [7:0] METH_LS_POS = 8'h12;
  localparam logic [7:0] METH_PRE_A = 8'h23;
  localparam logic [7:0] METH_PRE_B = 8'h25;
  localparam logic [1:0] MODE_TWO = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_ONEWAY = 2'h2;
  localparam logic [1:0] MODE_PUSH = 2'h3;
  localparam logic [1:0] TZ_OFF = 2'h0;
  localparam logic [1:0] TZ_TIM = 2'h1;
  localparam logic [1:0] TZ_ZERO = 2'h2;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DIR_BIT = 2;
  localparam int CFG_INPUT_A_BIT = 3;
  localparam int CFG_TZ_LSB = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam logic [7:0] ALARM_NONE = 8'h00;
  localparam logic [7:0] ALARM_HOME_ERR = 8'h62;
  localparam logic [1:0] SPD_STOP = 2'h0;
  localparam logic [1:0] SPD_SW = 2'h1;
  localparam logic [1:0] SPD_START = 2'h2;
  localparam logic [1:0] SPD_ZERO = 2'h3;
  typedef struct packed {
    logic fwd;
    logic rev;
    logic home;
    logic input_a;
    logic tim;
    logic zero;
    logic pressed;
  } hseq_pins_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_LEAVE, ST_DECEL, ST_OUT, ST_MOVE, ST_EXT
  } hseq_state_t;
endpackage : hseq_pkg

// *** hw/hseq_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module hseq_sync #(
  parameter int W = 7
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hseq_sync_st_t;
  hseq_sync_st_t s;
  hseq_sync_st_t next_s;
  always_comb begin
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign q_o = s.s2;
endmodule : hseq_sync

// *** hw/hseq_step_gen.sv ***
// Phase accumulator that turns a step rate in Hz into one-cycle step ticks.
`timescale 1ns/1ps
module hseq_step_gen
  import hseq_pkg::*;
#(
  parameter logic [31:0] CLK_HZ_P = CLK_HZ
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [31:0] speed_i,
  output logic tick_o
);
  typedef struct packed {
    logic [32:0] acc;
    logic tick;
  } hseq_sg_st_t;
  hseq_sg_st_t s;
  hseq_sg_st_t next_s;
  logic [32:0] sum;
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    sum = s.acc + {1'b0, speed_i};
    if (!en_i) begin
      next_s.acc = '0;
    end else if (sum >= {1'b0, CLK_HZ_P}) begin
      next_s.acc = sum - {1'b0, CLK_HZ_P};
      next_s.tick = 1'b1;
    end else begin
      next_s.acc = sum;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign tick_o = s.tick;
endmodule : hseq_step_gen

// *** bench/hseq_motor_model.sv ***
// Behavioural motor with limit, home and stopper sensors for the homing bench.
`timescale 1ns/1ps
module hseq_motor_model
  import hseq_pkg::*;
#(
  parameter int LIM = 20,
  parameter int HW = 2,
  parameter int STOP = 15
) (
  input wire logic mclk_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  input wire logic [2:0] ext_i,
  output hseq_pins_t pins_o,
  output logic [31:0] pos_o,
  output logic [31:0] lim_exit_o,
  output logic [31:0] home_exit_o,
  output logic [31:0] run_len_o
);
  int p = 0;
  int np;
  int lx = 0;
  int hx = 0;
  int rl = 0;
  logic last_dir = 1'b0;
  function automatic logic lim(input int v);
    return v >= LIM || v <= -LIM;
  endfunction : lim
  function automatic logic hom(input int v);
    return v >= -HW && v <= HW;
  endfunction : hom
  assign np = dir_i ? p + 1 : p - 1;
  // The stopper only sits at the positive end, so it never masks a limit exit.
  assign pins_o = {p >= LIM, p <= -LIM, hom(p), ext_i, p >= STOP};
  assign pos_o = 32'(p);
  assign lim_exit_o = 32'(lx);
  assign home_exit_o = 32'(hx);
  assign run_len_o = 32'(rl);
  always @(posedge mclk_i) begin
    if (load_i) begin
      p <= $signed(load_val_i);
      rl <= 0;
    end else if (step_i) begin
      p <= np;
      rl <= (dir_i == last_dir) ? rl + 1 : 1;
      last_dir <= dir_i;
      if (lim(p) && !lim(np)) begin
        lx <= np;
      end
      if (hom(p) && !hom(np)) begin
        hx <= np;
      end
    end
  end
endmodule : hseq_motor_model

// *** bench/hseq_top_tb.sv ***
// Self-checking bench for the homing sequencer driving a motor model.
`timescale 1ns/1ps
module hseq_top_tb;
  import hseq_pkg::*;
  localparam logic [31:0] FAST = 32'h017D_7840;
  localparam logic [31:0] BACK = 32'h0000_0008;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, step, dir, busy, done, error, irq;
  logic [7:0] alarm;
  logic [31:0] position, m_pos, m_lx, m_hx, m_rl;
  hseq_pins_t pins;
  logic op_en = 1'b0;
  logic load = 1'b0;
  logic [31:0] load_val = '0;
  logic [2:0] ext = '0;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  hseq_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pins_i(pins), .op_enabled_i(op_en),
    .step_o(step), .dir_o(dir), .busy_o(busy), .done_o(done), .error_o(error),
    .alarm_o(alarm), .position_o(position), .irq_o(irq));
  hseq_motor_model i_motor (.mclk_i(mclk_i), .step_i(step), .dir_i(dir), .load_i(load),
    .load_val_i(load_val), .ext_i(ext), .pins_o(pins), .pos_o(m_pos), .lim_exit_o(m_lx),
    .home_exit_o(m_hx), .run_len_o(m_rl));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic chkf(input logic got, input logic exp);
    check({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask : chkf
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
  endtask : rd_chk
  task automatic run(input logic [7:0] m, input logic [31:0] c, input logic [31:0] p0);
    @(posedge mclk_i);
    load <= 1'b1;
    load_val <= p0;
    @(posedge mclk_i);
    load <= 1'b0;
    wr(OFS_METHOD, {24'h00_0000, m});
    wr(OFS_CFG, c);
    wr(OFS_CMD, 32'h0000_0001);
  endtask : run
  task automatic wait_end();
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < 20000 && busy === 1'b1; i++) @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
  endtask : wait_end
  task automatic pulse_ext(input logic [2:0] v);
    ext <= v;
    repeat (4) @(posedge mclk_i);
    ext <= 3'h0;
  endtask : pulse_ext
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd_chk(OFS_METHOD, 32'h0000_00FF);
    rd_chk(OFS_CFG, 32'h0000_0005);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h3C, 32'h0000_0000, r, e);
    chkf(e, 1'b1);
    check(r, 32'h0000_0000);
    // Fast step rates keep every sequence to a few hundred cycles.
    wr(OFS_SPD_SW, FAST);
    wr(OFS_SPD_ZERO, FAST);
    wr(OFS_SPD_START, FAST);
    wr(OFS_BACK2, BACK);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    $display("test regs done");
  endtask : t_regs
  task automatic t_limit();
    logic [7:0] meth [4] = '{METH_LS_NEG, METH_LS_POS, METH_VENDOR, METH_VENDOR};
    logic [31:0] cfg [4] = '{32'h0000_0005, 32'h0000_0005, 32'h0000_0000, 32'h0000_0004};
    for (int k = 0; k < 4; k++) begin
      run(meth[k], cfg[k], 32'h0000_0000);
      wait_end();
      chkf(done, 1'b1);
      check(position, 32'h0000_0000);
      check(m_lx, k[0] ? 32'h0000_0013 : 32'hFFFF_FFED);
      check(m_pos, k[0] ? m_lx - BACK : m_lx + BACK);
    end
    $display("test limit methods done");
  endtask : t_limit
  task automatic t_preset();
    run(METH_PRE_A, 32'h0000_0005, 32'h0000_0007);
    wait_end();
    chkf(done, 1'b1);
    check(m_pos, 32'h0000_0007);
    op_en <= 1'b1;
    run(METH_PRE_B, 32'h0000_0005, 32'h0000_0007);
    wait_end();
    chkf(error, 1'b1);
    op_en <= 1'b0;
    run(METH_PRE_B, 32'h0000_0005, 32'h0000_0003);
    wait_end();
    chkf(done, 1'b1);
    check(position, 32'h0000_0000);
    $display("test preset done");
  endtask : t_preset
  task automatic t_three();
    run(METH_VENDOR, 32'h0000_0005, 32'h0000_000F);
    wait_end();
    chkf(done, 1'b1);
    chkf(pins.home, 1'b1);
    check(m_lx, 32'h0000_0013);
    run(METH_VENDOR, 32'h0000_0015, 32'hFFFF_FFF6);
    for (int i = 0; i < 5000 && pins.home !== 1'b1; i++) @(posedge mclk_i);
    repeat (12) @(posedge mclk_i);
    chkf(busy, 1'b1);
    pulse_ext(3'h2);
    wait_end();
    chkf(done, 1'b1);
    chkf(pins.home, 1'b1);
    $display("test three sensor done");
  endtask : t_three
  task automatic t_two_ext();
    logic [31:0] cfg [2] = '{32'h0000_0008, 32'h0000_0020};
    logic [2:0] sig [2] = '{3'h4, 3'h1};
    for (int k = 0; k < 2; k++) begin
      run(METH_VENDOR, cfg[k], 32'h0000_0000);
      // The way down passes the same position, so wait for the turn at the limit first.
      for (int i = 0; i < 5000 && dir !== 1'b1; i++) @(posedge mclk_i);
      for (int i = 0; i < 5000 && m_pos !== 32'hFFFF_FFF7; i++) @(posedge mclk_i);
      chkf(busy, 1'b1);
      pulse_ext(sig[k]);
      wait_end();
      chkf(done, 1'b1);
      check(m_pos, 32'hFFFF_FFF7);
      check(position, 32'h0000_0000);
    end
    $display("test two sensor extra signal done");
  endtask : t_two_ext
  task automatic t_oneway();
    wr(OFS_DECEL, 32'h0000_0002);
    wr(OFS_ONEWAY, 32'h0000_0006);
    run(METH_VENDOR, 32'h0000_0002, 32'h0000_000A);
    wait_end();
    chkf(done, 1'b1);
    check(m_hx, 32'hFFFF_FFFD);
    check(m_pos, m_hx - 32'h0000_0006);
    wr(OFS_IRQ_ST, 32'h0000_0003);
    wr(OFS_DECEL, 32'h0000_000C);
    run(METH_VENDOR, 32'h0000_0002, 32'h0000_000A);
    wait_end();
    chkf(error, 1'b1);
    check({24'h00_0000, alarm}, 32'h0000_0062);
    rd_chk(OFS_STATUS, 32'h0000_6204);
    rd_chk(OFS_IRQ_ST, 32'h0000_0002);
    chkf(irq, 1'b1);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge mclk_i);
    chkf(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    wr(OFS_IRQ_ST, 32'h0000_0002);
    repeat (2) @(posedge mclk_i);
    chkf(irq, 1'b0);
    wr(OFS_DECEL, 32'h0000_0002);
    $display("test one way done");
  endtask : t_oneway
  task automatic t_push();
    wr(OFS_PUSH1, 32'h0000_0004);
    wr(OFS_PUSH2, 32'h0000_0006);
    run(METH_VENDOR, 32'h0000_0007, 32'h0000_0000);
    for (int i = 0; i < 5000 && m_pos !== 32'h0000_0005; i++) @(posedge mclk_i);
    for (int i = 0; i < 5000 && dir !== 1'b0; i++) @(posedge mclk_i);
    for (int i = 0; i < 5000 && dir !== 1'b1; i++) @(posedge mclk_i);
    check(m_rl, 32'h0000_0004);
    wait_end();
    chkf(done, 1'b1);
    check(m_rl, 32'h0000_0006);
    $display("test push done");
  endtask : t_push
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  // A hang counts as a mismatch and still reaches the closing report.
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_limit();
    t_preset();
    t_three();
    t_two_ext();
    t_oneway();
    t_push();
    print_verdict();
  end
endmodule : hseq_top_tb
